//--- hdl/hbs_regs.svh
// register offsets, reset values and timing counts of the holding brake sequencer
// assumes a 25 MHz aclk and a 32-bit axi4-lite register bus
`ifndef HBS_REGS_SVH
`define HBS_REGS_SVH
`define HBS_OFF_CMD_DELAY     12'h000
`define HBS_OFF_ZERO_SPEED    12'h004
`define HBS_OFF_POWER_HOLD    12'h008
`define HBS_OFF_MAX_WAIT      12'h00C
`define HBS_OFF_CONTROL       12'h010
`define HBS_OFF_STATUS        12'h014
`define HBS_RST_CMD_DELAY     16'h00FA
`define HBS_RST_ZERO_SPEED    16'h001E
`define HBS_RST_POWER_HOLD    16'h0096
`define HBS_RST_MAX_WAIT      16'h01F4
`define HBS_RST_CONTROL       1'b0
`define HBS_STATIC_SPEED_RPM  16'h0014
`define HBS_DYN_HOLD_MS       16'h0032
`define HBS_CLK_HZ            25000000
`define HBS_TICK_MS           1
`define HBS_TICK_CYCLES       ((`HBS_CLK_HZ / 1000) * `HBS_TICK_MS)
`define HBS_CTL_BRAKE_MAP_BIT 0
`endif

//--- hdl/hbs_pkg.sv
// types shared by the holding brake sequencer
// assumes hbs_regs.svh provides the numeric constants
package hbs_pkg;
  typedef enum logic [4:0] {
    HBS_ST_OFF      = 5'b0_0001,
    HBS_ST_RUN      = 5'b0_0010,
    HBS_ST_DYN_WAIT = 5'b0_0100,
    HBS_ST_HOLD     = 5'b0_1000,
    HBS_ST_DONE     = 5'b1_0000
  } hbs_state_e;

  typedef struct packed {
    logic brake_release;
    logic motor_power;
    logic cmd_accept;
  } hbs_drive_s;
endpackage : hbs_pkg

//--- hdl/hbs_top.sv
// holding brake sequencer: enable-driven brake, power and command gating, axi4-lite registers
// assumes servo_enable_in is asynchronous; speed comes from same-clock logic
`timescale 1ns/100ps
`include "hbs_regs.svh"
module hbs_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        servo_enable_in,
  input  wire logic [15:0] filtered_motor_speed,
  input  wire logic        motion_cmd_valid_in,
  output wire logic        motion_cmd_valid_out,
  output wire logic        cmd_accept_out,
  output wire logic        motor_power_out,
  output wire logic        brake_release_out_n
);
  function automatic logic [15:0] hbs_wmerge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    hbs_wmerge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : hbs_wmerge

  logic [15:0] cmd_delay_reg;
  logic [15:0] zero_speed_reg;
  logic [15:0] power_hold_reg;
  logic [15:0] max_wait_reg;
  logic        brake_map_reg;
  logic [11:0] awaddr_reg;
  logic        aw_have_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        w_have_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        en_s1_reg;
  logic        en_s2_reg;
  logic        en_d_reg;
  logic [14:0] tick_cnt_reg;
  logic [15:0] ms_cnt_reg;
  logic        accept_reg;
  logic        use_static_reg;
  hbs_pkg::hbs_state_e state_reg;
  hbs_pkg::hbs_state_e state_next;
  hbs_pkg::hbs_drive_s drive_reg;
  hbs_pkg::hbs_drive_s drive_next;

  // write channel: address and data taken in either order, response once both held
  wire do_write = aw_have_reg && w_have_reg && !bvalid_reg;
  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready  = !w_have_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  wire [11:0] wa = awaddr_reg & 12'hFFC;
  wire wr_cmd   = do_write && (wa == `HBS_OFF_CMD_DELAY);
  wire wr_zero  = do_write && (wa == `HBS_OFF_ZERO_SPEED);
  wire wr_hold  = do_write && (wa == `HBS_OFF_POWER_HOLD);
  wire wr_wait  = do_write && (wa == `HBS_OFF_MAX_WAIT);
  wire wr_ctl   = do_write && (wa == `HBS_OFF_CONTROL);
  wire wr_known = wr_cmd || wr_zero || wr_hold || wr_wait || wr_ctl || (wa == `HBS_OFF_STATUS);

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  wire [11:0] ra = s_axi_araddr & 12'hFFC;
  wire do_read = s_axi_arvalid && !rvalid_reg;
  wire [31:0] status_word = {24'h0000_00, 3'b000, state_reg == hbs_pkg::HBS_ST_DYN_WAIT,
                             use_static_reg, drive_reg.cmd_accept, drive_reg.motor_power,
                             drive_reg.brake_release};
  wire rd_known = (ra == `HBS_OFF_CMD_DELAY) || (ra == `HBS_OFF_ZERO_SPEED) || (ra == `HBS_OFF_POWER_HOLD) ||
                  (ra == `HBS_OFF_MAX_WAIT) || (ra == `HBS_OFF_CONTROL) || (ra == `HBS_OFF_STATUS);
  wire [31:0] rd_word = (ra == `HBS_OFF_CMD_DELAY)  ? {16'h0000, cmd_delay_reg}  :
                        (ra == `HBS_OFF_ZERO_SPEED) ? {16'h0000, zero_speed_reg} :
                        (ra == `HBS_OFF_POWER_HOLD) ? {16'h0000, power_hold_reg} :
                        (ra == `HBS_OFF_MAX_WAIT)   ? {16'h0000, max_wait_reg}   :
                        (ra == `HBS_OFF_CONTROL)    ? {31'h0000_0000, brake_map_reg} :
                        (ra == `HBS_OFF_STATUS)     ? status_word : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      awaddr_reg  <= 12'h000;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (do_write) begin
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_known ? 2'b00 : 2'b10;
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= 2'b00;
    end else if (do_read) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_known ? 2'b00 : 2'b10;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // parameters take effect immediately, also mid-sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_delay_reg  <= `HBS_RST_CMD_DELAY;
      zero_speed_reg <= `HBS_RST_ZERO_SPEED;
      power_hold_reg <= `HBS_RST_POWER_HOLD;
      max_wait_reg   <= `HBS_RST_MAX_WAIT;
      brake_map_reg  <= `HBS_RST_CONTROL;
    end else begin
      if (wr_cmd)
        cmd_delay_reg <= hbs_wmerge(cmd_delay_reg, wdata_reg, wstrb_reg) & 16'h7FFF;
      if (wr_zero)
        zero_speed_reg <= hbs_wmerge(zero_speed_reg, wdata_reg, wstrb_reg) & 16'h7FFF;
      if (wr_hold)
        power_hold_reg <= hbs_wmerge(power_hold_reg, wdata_reg, wstrb_reg) & 16'h7FFF;
      if (wr_wait)
        max_wait_reg <= hbs_wmerge(max_wait_reg, wdata_reg, wstrb_reg) & 16'h7FFF;
      if (wr_ctl && wstrb_reg[0])
        brake_map_reg <= wdata_reg[`HBS_CTL_BRAKE_MAP_BIT];
    end
  end

  // enable pin crosses in through two flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_s1_reg <= 1'b0;
      en_s2_reg <= 1'b0;
      en_d_reg  <= 1'b0;
    end else begin
      en_s1_reg <= servo_enable_in;
      en_s2_reg <= en_s1_reg;
      en_d_reg  <= en_s2_reg;
    end
  end
  wire en_rise = en_s2_reg && !en_d_reg;
  wire en_fall = !en_s2_reg && en_d_reg;

  // millisecond timebase and elapsed-ms counter, restarted on every edge and on hold entry
  wire tick     = (tick_cnt_reg == 15'(`HBS_TICK_CYCLES - 1));
  wire restart  = en_rise || en_fall || (state_reg == hbs_pkg::HBS_ST_DYN_WAIT && state_next == hbs_pkg::HBS_ST_HOLD);
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      tick_cnt_reg <= 15'h0000;
      ms_cnt_reg   <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick ? 15'h0000 : tick_cnt_reg + 15'h0001;
      if (tick && ms_cnt_reg != 16'hFFFF)
        ms_cnt_reg <= ms_cnt_reg + 16'h0001;
    end
  end

  wire speed_low  = filtered_motor_speed < `HBS_STATIC_SPEED_RPM;
  wire dyn_lock   = (filtered_motor_speed < zero_speed_reg) || (ms_cnt_reg > max_wait_reg);
  wire [15:0] hold_ms = use_static_reg ? power_hold_reg : `HBS_DYN_HOLD_MS;
  wire hold_done  = ms_cnt_reg >= hold_ms;

  always_comb begin
    state_next = state_reg;
    drive_next = drive_reg;
    case (state_reg)
      hbs_pkg::HBS_ST_OFF, hbs_pkg::HBS_ST_DONE: begin
        drive_next = '0;
        if (en_rise) begin
          state_next = hbs_pkg::HBS_ST_RUN;
          drive_next.motor_power   = 1'b1;
          drive_next.brake_release = brake_map_reg;
        end
      end
      hbs_pkg::HBS_ST_RUN: begin
        drive_next.cmd_accept = drive_reg.cmd_accept || (ms_cnt_reg >= cmd_delay_reg);
        if (en_fall) begin
          drive_next.cmd_accept = 1'b0;
          if (speed_low || !brake_map_reg) begin
            state_next = hbs_pkg::HBS_ST_HOLD;
            drive_next.brake_release = 1'b0;
          end else begin
            state_next = hbs_pkg::HBS_ST_DYN_WAIT;
          end
        end
      end
      hbs_pkg::HBS_ST_DYN_WAIT: begin
        if (dyn_lock) begin
          state_next = hbs_pkg::HBS_ST_HOLD;
          drive_next.brake_release = 1'b0;
        end
      end
      hbs_pkg::HBS_ST_HOLD: begin
        if (hold_done) begin
          state_next = hbs_pkg::HBS_ST_DONE;
          drive_next.motor_power = 1'b0;
        end
      end
      default: begin
        state_next = hbs_pkg::HBS_ST_OFF;
        drive_next = '0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg      <= hbs_pkg::HBS_ST_OFF;
      drive_reg      <= '0;
      use_static_reg <= 1'b0;
      accept_reg     <= 1'b0;
    end else begin
      state_reg  <= state_next;
      drive_reg  <= drive_next;
      accept_reg <= drive_next.cmd_accept;
      if (en_fall)
        use_static_reg <= speed_low || !brake_map_reg;
    end
  end

  // commands arriving during the accept delay are dropped, not queued
  assign motion_cmd_valid_out = motion_cmd_valid_in && accept_reg;
  assign cmd_accept_out       = accept_reg;
  assign motor_power_out      = drive_reg.motor_power;
  // fixed low-active drive: a high-active pin would release during power-up
  assign brake_release_out_n  = !drive_reg.brake_release;
endmodule : hbs_top

//--- testbench/hbs_top_props.sv
// port assertions for the brake sequencer
// assumes a bind from the bench top, one clock domain
`timescale 1ns/100ps
module hbs_top_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        servo_enable_in,
  input wire logic [15:0] filtered_motor_speed,
  input wire logic        motion_cmd_valid_in,
  input wire logic        motion_cmd_valid_out,
  input wire logic        cmd_accept_out,
  input wire logic        motor_power_out,
  input wire logic        brake_release_out_n
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire slow = filtered_motor_speed < 16'h0014;
  // bit 15 set is above any 15-bit threshold
  wire fast = filtered_motor_speed[15];
  sequence s_rise;
    !servo_enable_in && !motor_power_out ##1 servo_enable_in [*4];
  endsequence
  sequence s_fall(logic c);
    servo_enable_in && !brake_release_out_n && c ##1 (!servo_enable_in && c) [*4];
  endsequence
  property p_gate;
    motion_cmd_valid_out == (motion_cmd_valid_in && cmd_accept_out);
  endproperty
  property p_rel;
    !brake_release_out_n |-> motor_power_out;
  endproperty
  property p_acc;
    cmd_accept_out |-> motor_power_out;
  endproperty
  property p_pair;
    $fell(brake_release_out_n) |-> $rose(motor_power_out);
  endproperty
  property p_hold;
    $rose(brake_release_out_n) |-> motor_power_out [*8];
  endproperty
  property p_off;
    $fell(motor_power_out) |-> brake_release_out_n && !cmd_accept_out;
  endproperty
  property p_rise;
    s_rise |-> ##[0:3] motor_power_out;
  endproperty
  property p_static;
    s_fall(slow) |-> ##[0:3] brake_release_out_n;
  endproperty
  property p_dyn;
    s_fall(fast) ##1 fast [*3] |-> !brake_release_out_n;
  endproperty
  a_gate: assert property (p_gate) else $error("command gate wrong");
  a_rel: assert property (p_rel) else $error("released unpowered");
  a_acc: assert property (p_acc) else $error("accept unpowered");
  a_pair: assert property (p_pair) else $error("release without power rise");
  a_hold: assert property (p_hold) else $error("power cut at lock");
  a_off: assert property (p_off) else $error("power cut while released");
  a_rise: assert property (p_rise) else $error("no power after enable");
  a_static: assert property (p_static) else $error("static lock late");
  a_dyn: assert property (p_dyn) else $error("dynamic lock early");
endmodule : hbs_top_props

//--- testbench/hbs_ctrl_model.sv
// motion controller model: servo enable and command strobes
// assumes enable requests come from the bench
`timescale 1ns/100ps
module hbs_ctrl_model (
  input  wire logic aclk,
  input  wire logic enable_req,
  input  wire logic cmd_accept_out,
  output logic      servo_enable_in,
  output logic      motion_cmd_valid_in
);
  initial begin
    servo_enable_in = 1'b0;
    motion_cmd_valid_in = 1'b0;
  end
  always @(posedge aclk) begin
    servo_enable_in <= enable_req;
    motion_cmd_valid_in <= cmd_accept_out && !motion_cmd_valid_in;
  end
endmodule : hbs_ctrl_model

//--- testbench/hbs_top_test.sv
// bench for the brake sequencer: registers, static and dynamic stops
// assumes 25 MHz clock; ms settings kept at 0 or 1 for run length
`timescale 1ns/100ps
`include "hbs_regs.svh"
module hbs_top_test;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] aa = 12'h000;
  logic [31:0] wd = 32'h0000_0000;
  logic        awv = 1'b0, wv = 1'b0, arv = 1'b0, en_req = 1'b0;
  logic [15:0] spd = 16'h0000;
  wire  logic  awr, wr, bv, arr, rv, cin, cout, acc, pow, brk_n, en;
  wire  logic [1:0]  br, rr;
  wire  logic [31:0] rd;
  logic [31:0] d;
  logic [31:0] r;
  int          n_mismatch = 0, num_checks = 0;
  logic [11:0] ra[6] = '{`HBS_OFF_CMD_DELAY, `HBS_OFF_ZERO_SPEED, `HBS_OFF_POWER_HOLD, `HBS_OFF_MAX_WAIT,
                         `HBS_OFF_CONTROL, 12'h020};
  logic [31:0] rx[6] = '{32'h0000_00FA, 32'h0000_001E, 32'h0000_0096, 32'h0000_01F4, 32'h0000_0000, 32'h0000_0000};
  logic [31:0] rs[6] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0002};
  always #20 aclk = ~aclk;
  hbs_top i_hbs_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(1'b1), .s_axi_araddr(aa), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1), .servo_enable_in(en), .filtered_motor_speed(spd),
    .motion_cmd_valid_in(cin), .motion_cmd_valid_out(cout), .cmd_accept_out(acc), .motor_power_out(pow),
    .brake_release_out_n(brk_n));
  hbs_ctrl_model i_hbs_ctrl_model (.aclk(aclk), .enable_req(en_req), .cmd_accept_out(acc),
    .servo_enable_in(en), .motion_cmd_valid_in(cin));
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  // single task for both directions: the bus carries one of each at most
  task automatic axi(input logic w, input logic [11:0] a, input logic [31:0] v);
    logic ta, tw, tr;
    int   i;
    @(posedge aclk);
    aa <= a;
    wd <= v;
    awv <= w;
    wv <= w;
    arv <= !w;
    for (i = 0; i < 50; i++) begin
      @(negedge aclk);
      ta = awv && awr || arv && arr;
      tw = wv && wr;
      tr = w ? bv : rv;
      d = rd;
      r = {30'h0000_0000, w ? br : rr};
      @(posedge aclk);
      if (ta) begin
        awv <= 1'b0;
        arv <= 1'b0;
      end
      if (tw) wv <= 1'b0;
      if (tr) break;
    end
    if (i == 50) begin
      n_mismatch++;
      end_of_test();
    end
  endtask : axi
  task automatic wait_on(input int s, input logic v, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(negedge aclk);
      if ((s == 0 ? pow : s == 1 ? brk_n : acc) === v) break;
    end
    if (i == lim) begin
      n_mismatch++;
      end_of_test();
    end
  endtask : wait_on
  task drv(input logic e, input logic [15:0] s);
    @(posedge aclk);
    en_req <= e;
    spd <= s;
  endtask : drv
  task rst;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(negedge aclk);
    chk({pow, brk_n, acc}, 3'b010);
    @(posedge aclk);
    aresetn <= 1'b1;
  endtask : rst
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      axi(1'b0, ra[k], 32'h0000_0000);
      chk(d, rx[k]);
      chk(r, rs[k]);
    end
    axi(1'b1, `HBS_OFF_ZERO_SPEED, 32'hFFFF_FFFF);
    axi(1'b0, `HBS_OFF_ZERO_SPEED, 32'h0000_0000);
    chk(d, 32'h0000_7FFF);
    axi(1'b1, 12'h020, 32'h0000_0001);
    chk(r, 32'h0000_0002);
    $display("registers done");
    drv(1'b1, 16'h0000);
    wait_on(0, 1'b1, 20);
    chk(brk_n, 1'b1);
    drv(1'b0, 16'h0000);
    rst();
    axi(1'b1, `HBS_OFF_CONTROL, 32'h0000_0001);
    axi(1'b1, `HBS_OFF_CMD_DELAY, 32'h0000_0000);
    axi(1'b1, `HBS_OFF_POWER_HOLD, 32'h0000_0001);
    drv(1'b1, 16'h0000);
    wait_on(1, 1'b0, 20);
    chk(pow, 1'b1);
    wait_on(2, 1'b1, 20);
    @(negedge aclk);
    chk({cin, cout}, 2'b11);
    axi(1'b0, `HBS_OFF_STATUS, 32'h0000_0000);
    chk(d, 32'h0000_0007);
    drv(1'b0, 16'h0013);
    wait_on(1, 1'b1, 20);
    chk(pow, 1'b1);
    repeat (24000) @(negedge aclk);
    chk(pow, 1'b1);
    wait_on(0, 1'b0, 2000);
    $display("static stop done");
    // threshold at 20 so exactly 20 rpm takes the dynamic path and stays released
    axi(1'b1, `HBS_OFF_ZERO_SPEED, 32'h0000_0014);
    drv(1'b1, 16'h0000);
    wait_on(1, 1'b0, 20);
    drv(1'b0, 16'h0014);
    repeat (40) @(negedge aclk);
    chk(brk_n, 1'b0);
    drv(1'b0, 16'h0013);
    wait_on(1, 1'b1, 20);
    chk(pow, 1'b1);
    rst();
    $display("dynamic speed stop done");
    axi(1'b1, `HBS_OFF_CONTROL, 32'h0000_0001);
    axi(1'b1, `HBS_OFF_CMD_DELAY, 32'h0000_0001);
    axi(1'b1, `HBS_OFF_MAX_WAIT, 32'h0000_0000);
    drv(1'b1, 16'h0000);
    wait_on(1, 1'b0, 20);
    repeat (20000) @(negedge aclk);
    chk(acc, 1'b0);
    wait_on(2, 1'b1, 6000);
    drv(1'b0, 16'h8000);
    repeat (20000) @(negedge aclk);
    chk(brk_n, 1'b0);
    wait_on(1, 1'b1, 6000);
    chk(pow, 1'b1);
    $display("dynamic timeout stop done");
    end_of_test();
  end
endmodule : hbs_top_test
bind hbs_top hbs_top_props i_hbs_top_props (.aclk(aclk), .aresetn(aresetn), .servo_enable_in(servo_enable_in),
  .filtered_motor_speed(filtered_motor_speed), .motion_cmd_valid_in(motion_cmd_valid_in),
  .motion_cmd_valid_out(motion_cmd_valid_out), .cmd_accept_out(cmd_accept_out),
  .motor_power_out(motor_power_out), .brake_release_out_n(brake_release_out_n));
